// File: hw/bridge_hdr_regs.svh
`ifndef BRIDGE_HDR_REGS_SVH
`define BRIDGE_HDR_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses within configuration space)
// ----------------------------------------------------------------------
`define OFF_HEADER_KIND   12'h00E
`define OFF_SELF_TEST     12'h00F
`define OFF_BASE_SLOT_0   12'h010
`define OFF_BASE_SLOT_1   12'h014
`define OFF_UP_BUS        12'h018
`define OFF_DOWN_BUS      12'h019
`define OFF_HIGH_BUS      12'h01A
`define OFF_DOWN_LAT      12'h01B
`define OFF_IO_BASE       12'h01C
`define OFF_IO_TOP        12'h01D
`define OFF_CAP_LOCK      12'h200

// ----------------------------------------------------------------------
// fixed values and reset values
// ----------------------------------------------------------------------
`define VAL_HEADER_KIND   8'h01
`define VAL_ZERO8         8'h00
`define VAL_ZERO32        32'h0000_0000
`define RST_BUS           8'h00
`define RST_IO_BASE_HI    4'hF
`define RST_IO_TOP_HI     4'h0
`define RST_IO_CAP        1'h1
`define RST_LOCK          1'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IO_CAP_BIT        0
`define IO_HI_MSB         7
`define IO_HI_LSB         4
`define IO_LOW_ONES       12'hFFF
`define IO_LOW_ZERO       12'h000
`define IO_UPPER_ZERO     16'h0000

`endif

// File: hw/bridge_hdr_pkg.sv
package bridge_hdr_pkg;

   // configuration access request from the bus side
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } cfg_req_s;

   // I/O transaction lookup into the forwarding window
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } io_query_s;

   // decoded register selector
   typedef enum {
      SEL_HEADER_KIND,
      SEL_SELF_TEST,
      SEL_BASE_SLOT_0,
      SEL_BASE_SLOT_1,
      SEL_UP_BUS,
      SEL_DOWN_BUS,
      SEL_HIGH_BUS,
      SEL_DOWN_LAT,
      SEL_IO_BASE,
      SEL_IO_TOP,
      SEL_CAP_LOCK,
      SEL_NONE
   } reg_sel_e;

endpackage : bridge_hdr_pkg

// File: hw/bridge_sync2.sv
`timescale 1ns/1ps
`include "bridge_hdr_regs.svh"

// ----------------------------------------------------------------------
// two-stage synchroniser for a level from outside the clock domain
// ----------------------------------------------------------------------
module bridge_sync2 (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : bridge_sync2

// File: hw/io_window_match.sv
`timescale 1ns/1ps
`include "bridge_hdr_regs.svh"

// ----------------------------------------------------------------------
// I/O forwarding window compare, registered result
// ----------------------------------------------------------------------
module io_window_match (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire bridge_hdr_pkg::io_query_s query,
   input  wire logic [3:0]               base_hi,
   input  wire logic [3:0]               top_hi,
   input  wire logic                     wide_io,
   output logic                          hit_valid,
   output logic                          hit
);
   logic [31:0] lo_addr;
   logic [31:0] hi_addr;
   logic        upper_ok;
   logic        in_win;

   // window bounds; limit low bits assumed all ones
   always_comb begin
      lo_addr  = {`IO_UPPER_ZERO, base_hi, `IO_LOW_ZERO};
      hi_addr  = {`IO_UPPER_ZERO, top_hi, `IO_LOW_ONES};
      // narrow or wide addressing alike: upper address bits must be zero
      upper_ok = wide_io ? (query.addr[31:16] == `IO_UPPER_ZERO)
                         : (query.addr[31:16] == `IO_UPPER_ZERO);
      // base above limit gives an empty window
      in_win   = (base_hi <= top_hi) && upper_ok &&
                 (query.addr >= lo_addr) && (query.addr <= hi_addr);
   end

   // answer one cycle after the query
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_valid <= 1'b0;
         hit       <= 1'b0;
      end else begin
         hit_valid <= query.valid;
         hit       <= query.valid && in_win;
      end
   end
endmodule : io_window_match

// File: hw/bridge_type1_header_regs.sv
// Operation
// - header kind reads fixed 0x01, read-only
// - self-test register reads zero, read-only
// - both base address slots read zero
// - upstream bus number writable, no effect
// - downstream bus number writable, resets zero
// - highest behind bus number writable, resets zero
// - downstream latency timer reads zero
// - io capability bit resets one, lock-guarded
// - io base high nibble writable, resets 0xF
// - io top bit0 mirrors capability bit
// - io top high nibble writable, resets zero
// - io window decides transaction forwarding
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "bridge_hdr_regs.svh"

module bridge_type1_header_regs (
   input  wire logic                      CORE_CLK,
   input  wire logic                      RESET_N,
   input  wire logic [11:0]               CFG_ADDR,
   input  wire logic [31:0]               CFG_WDATA,
   input  wire logic                      CFG_WR,
   input  wire logic                      CFG_RD,
   output logic      [31:0]               CFG_RDATA,
   input  wire logic                      CAP_LOCK_PIN,
   input  wire bridge_hdr_pkg::io_query_s IO_QUERY,
   output logic                           IO_HIT_VALID,
   output logic                           IO_FORWARD,
   output logic      [7:0]                DOWN_BUS_NUM,
   output logic      [7:0]                HIGH_BUS_NUM
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------

   // one decoder shared by the read and write paths
   function automatic bridge_hdr_pkg::reg_sel_e decode(
      input logic [11:0] a);
      bridge_hdr_pkg::reg_sel_e s;
      begin
         s = bridge_hdr_pkg::SEL_NONE;
         case (a)
            `OFF_HEADER_KIND: s = bridge_hdr_pkg::SEL_HEADER_KIND;
            `OFF_SELF_TEST:   s = bridge_hdr_pkg::SEL_SELF_TEST;
            `OFF_BASE_SLOT_0: s = bridge_hdr_pkg::SEL_BASE_SLOT_0;
            `OFF_BASE_SLOT_1: s = bridge_hdr_pkg::SEL_BASE_SLOT_1;
            `OFF_UP_BUS:      s = bridge_hdr_pkg::SEL_UP_BUS;
            `OFF_DOWN_BUS:    s = bridge_hdr_pkg::SEL_DOWN_BUS;
            `OFF_HIGH_BUS:    s = bridge_hdr_pkg::SEL_HIGH_BUS;
            `OFF_DOWN_LAT:    s = bridge_hdr_pkg::SEL_DOWN_LAT;
            `OFF_IO_BASE:     s = bridge_hdr_pkg::SEL_IO_BASE;
            `OFF_IO_TOP:      s = bridge_hdr_pkg::SEL_IO_TOP;
            `OFF_CAP_LOCK:    s = bridge_hdr_pkg::SEL_CAP_LOCK;
            default:          s = bridge_hdr_pkg::SEL_NONE;
         endcase
         return s;
      end
   endfunction : decode

   bridge_hdr_pkg::cfg_req_s req;
   bridge_hdr_pkg::reg_sel_e wsel;
   bridge_hdr_pkg::reg_sel_e rsel;

   // bundle the bus signals and decode both paths
   always_comb begin
      req.addr  = CFG_ADDR;
      req.wdata = CFG_WDATA;
      req.wr    = CFG_WR;
      req.rd    = CFG_RD;
      wsel      = req.wr ? decode(req.addr) : bridge_hdr_pkg::SEL_NONE;
      rsel      = decode(req.addr);
   end

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] up_bus_q;
   logic [7:0] down_bus_q;
   logic [7:0] high_bus_q;
   logic [3:0] io_base_hi_q;
   logic [3:0] io_top_hi_q;
   logic       io_cap_q;
   logic       lock_sw_q;
   logic       lock_pin_s;
   logic       cap_locked;

   // lock strap comes from a pin, so it is synchronised first
   bridge_sync2 u_lock_sync (
      .clk   (CORE_CLK),
      .rst_n (RESET_N),
      .din   (CAP_LOCK_PIN),
      .dout  (lock_pin_s)
   );

   // either the pin or the software lock freezes the capability bit
   assign cap_locked = lock_pin_s | lock_sw_q;

   // bus numbers; upstream copy is held only for software
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         up_bus_q   <= `RST_BUS;
         down_bus_q <= `RST_BUS;
         high_bus_q <= `RST_BUS;
      end else begin
         if (wsel == bridge_hdr_pkg::SEL_UP_BUS) begin
            up_bus_q <= req.wdata[7:0];
         end
         if (wsel == bridge_hdr_pkg::SEL_DOWN_BUS) begin
            down_bus_q <= req.wdata[7:0];
         end
         if (wsel == bridge_hdr_pkg::SEL_HIGH_BUS) begin
            high_bus_q <= req.wdata[7:0];
         end
      end
   end

   // io window nibbles; reserved bits 3:1 are not stored at all
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         io_base_hi_q <= `RST_IO_BASE_HI;
         io_top_hi_q  <= `RST_IO_TOP_HI;
      end else begin
         if (wsel == bridge_hdr_pkg::SEL_IO_BASE) begin
            io_base_hi_q <= req.wdata[`IO_HI_MSB:`IO_HI_LSB];
         end
         if (wsel == bridge_hdr_pkg::SEL_IO_TOP) begin
            io_top_hi_q <= req.wdata[`IO_HI_MSB:`IO_HI_LSB];
         end
      end
   end

   // capability bit: writable via the base register until locked
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         io_cap_q <= `RST_IO_CAP;
      end else if (wsel == bridge_hdr_pkg::SEL_IO_BASE && !cap_locked) begin
         io_cap_q <= req.wdata[`IO_CAP_BIT];
      end
   end

   // software lock is sticky until reset so it cannot be undone
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lock_sw_q <= `RST_LOCK;
      end else if (wsel == bridge_hdr_pkg::SEL_CAP_LOCK &&
                   req.wdata[0]) begin
         lock_sw_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [31:0] rdata_d;

   // fixed fields return constants; writes to them go nowhere
   always_comb begin
      rdata_d = `VAL_ZERO32;
      case (rsel)
         bridge_hdr_pkg::SEL_HEADER_KIND:
            rdata_d[7:0] = `VAL_HEADER_KIND;
         bridge_hdr_pkg::SEL_SELF_TEST:
            rdata_d[7:0] = `VAL_ZERO8;
         bridge_hdr_pkg::SEL_BASE_SLOT_0:
            rdata_d = `VAL_ZERO32;
         bridge_hdr_pkg::SEL_BASE_SLOT_1:
            rdata_d = `VAL_ZERO32;
         bridge_hdr_pkg::SEL_UP_BUS:
            rdata_d[7:0] = up_bus_q;
         bridge_hdr_pkg::SEL_DOWN_BUS:
            rdata_d[7:0] = down_bus_q;
         bridge_hdr_pkg::SEL_HIGH_BUS:
            rdata_d[7:0] = high_bus_q;
         bridge_hdr_pkg::SEL_DOWN_LAT:
            rdata_d[7:0] = `VAL_ZERO8;
         bridge_hdr_pkg::SEL_IO_BASE: begin
            rdata_d[`IO_HI_MSB:`IO_HI_LSB] = io_base_hi_q;
            rdata_d[`IO_CAP_BIT]           = io_cap_q;
         end
         bridge_hdr_pkg::SEL_IO_TOP: begin
            rdata_d[`IO_HI_MSB:`IO_HI_LSB] = io_top_hi_q;
            rdata_d[`IO_CAP_BIT]           = io_cap_q;
         end
         bridge_hdr_pkg::SEL_CAP_LOCK: begin
            rdata_d[0] = lock_sw_q;
            rdata_d[1] = lock_pin_s;
         end
         default:
            rdata_d = `VAL_ZERO32; // unmapped reads as zero
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CFG_RDATA <= `VAL_ZERO32;
      end else begin
         CFG_RDATA <= req.rd ? rdata_d : `VAL_ZERO32;
      end
   end

   // ----------------------------------------------------------------
   // forwarding
   // ----------------------------------------------------------------

   // window compare uses live register values
   io_window_match u_match (
      .clk       (CORE_CLK),
      .rst_n     (RESET_N),
      .query     (IO_QUERY),
      .base_hi   (io_base_hi_q),
      .top_hi    (io_top_hi_q),
      .wide_io   (io_cap_q),
      .hit_valid (IO_HIT_VALID),
      .hit       (IO_FORWARD)
   );

   // bus range exported for routing logic elsewhere in the switch
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DOWN_BUS_NUM <= `RST_BUS;
         HIGH_BUS_NUM <= `RST_BUS;
      end else begin
         DOWN_BUS_NUM <= down_bus_q;
         HIGH_BUS_NUM <= high_bus_q;
      end
   end

endmodule : bridge_type1_header_regs

// File: sim/bridge_type1_header_regs_monitor.sv
`timescale 1ns/1ps
`include "bridge_hdr_regs.svh"
// ----------------------------------------------------------------------
// register bank checker
// ----------------------------------------------------------------------
module bridge_type1_header_regs_monitor (
   input wire logic                      CORE_CLK,
   input wire logic                      RESET_N,
   input wire logic [11:0]               CFG_ADDR,
   input wire logic [31:0]               CFG_WDATA,
   input wire logic                      CFG_WR,
   input wire logic                      CFG_RD,
   input wire logic [31:0]               CFG_RDATA,
   input wire logic                      CAP_LOCK_PIN,
   input wire bridge_hdr_pkg::io_query_s IO_QUERY,
   input wire logic                      IO_HIT_VALID,
   input wire logic                      IO_FORWARD,
   input wire logic [7:0]                DOWN_BUS_NUM,
   input wire logic [7:0]                HIGH_BUS_NUM
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // read data stands only in the cycle after a read strobe
   a_rdata_idle: assert property (!CFG_RD |=> CFG_RDATA == 32'h0)
      else $error("read data not idle");
   a_hdr_fixed: assert property (CFG_RD &&
      CFG_ADDR == `OFF_HEADER_KIND
      |=> CFG_RDATA == 32'h1) else $error("header kind wrong");
   a_ro_zero: assert property (CFG_RD &&
      (CFG_ADDR == `OFF_SELF_TEST || CFG_ADDR == `OFF_DOWN_LAT)
      |=> CFG_RDATA == 32'h0) else $error("ro not 0");
   a_slot_zero: assert property (CFG_RD &&
      (CFG_ADDR == `OFF_BASE_SLOT_0 || CFG_ADDR == `OFF_BASE_SLOT_1)
      |=> CFG_RDATA == 32'h0) else $error("slot");
   a_io_resv: assert property (CFG_RD && (CFG_ADDR == `OFF_IO_BASE
      || CFG_ADDR == `OFF_IO_TOP) |=> CFG_RDATA[31:8] == 24'h0
      && CFG_RDATA[3:1] == 3'h0) else $error("io reserved bits set");
   a_hit_pulse: assert property (IO_QUERY.valid |=> IO_HIT_VALID)
      else $error("no lookup answer");
   a_hit_quiet: assert property (!IO_QUERY.valid |=> !IO_HIT_VALID
      && !IO_FORWARD) else $error("answer without query");
   a_upper_blk: assert property (IO_QUERY.valid &&
      IO_QUERY.addr[31:16] != 16'h0 |=> !IO_FORWARD)
      else $error("upper addr forwarded");
   a_down_export: assert property (CFG_WR &&
      CFG_ADDR == `OFF_DOWN_BUS
      |-> ##2 DOWN_BUS_NUM == $past(CFG_WDATA[7:0], 2))
      else $error("down bus");
   a_high_export: assert property (CFG_WR &&
      CFG_ADDR == `OFF_HIGH_BUS
      |-> ##2 HIGH_BUS_NUM == $past(CFG_WDATA[7:0], 2))
      else $error("high bus");
   // main scenarios seen at least once
   c_io_read: cover property (CFG_RD && CFG_ADDR == `OFF_IO_BASE);
   c_forward: cover property (IO_FORWARD);
   c_lock_wr: cover property (CFG_WR && CFG_ADDR == `OFF_CAP_LOCK);
endmodule : bridge_type1_header_regs_monitor

bind bridge_type1_header_regs bridge_type1_header_regs_monitor mon_u (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CFG_ADDR(CFG_ADDR),
   .CFG_WDATA(CFG_WDATA), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
   .CFG_RDATA(CFG_RDATA), .CAP_LOCK_PIN(CAP_LOCK_PIN),
   .IO_QUERY(IO_QUERY), .IO_HIT_VALID(IO_HIT_VALID),
   .IO_FORWARD(IO_FORWARD), .DOWN_BUS_NUM(DOWN_BUS_NUM),
   .HIGH_BUS_NUM(HIGH_BUS_NUM));

// File: sim/bridge_type1_header_regs_tb.sv
`timescale 1ns/1ps
`include "bridge_hdr_regs.svh"
// ----------------------------------------------------------------------
// register bank testbench
// ----------------------------------------------------------------------
module bridge_type1_header_regs_tb;
   logic                      clk, rst_n, wr, rd, pin, hit_v, fwd;
   logic [11:0]               addr;
   logic [31:0]               wdata, rdata;
   logic [7:0]                down_bus, high_bus, up_m, down_m, high_m;
   logic [3:0]                base_m, top_m;
   logic                      cap_m, lock_m, pin_m;
   bridge_hdr_pkg::io_query_s query;
   int                        failures, checked;
   logic [11:0] addrs [12] = '{`OFF_HEADER_KIND, `OFF_SELF_TEST,
      `OFF_BASE_SLOT_0, `OFF_BASE_SLOT_1, `OFF_UP_BUS, `OFF_DOWN_BUS,
      `OFF_HIGH_BUS, `OFF_DOWN_LAT, `OFF_IO_BASE, `OFF_IO_TOP,
      `OFF_CAP_LOCK, 12'h01E};

   bridge_type1_header_regs dut_u (.CORE_CLK(clk), .RESET_N(rst_n),
      .CFG_ADDR(addr), .CFG_WDATA(wdata), .CFG_WR(wr), .CFG_RD(rd),
      .CFG_RDATA(rdata), .CAP_LOCK_PIN(pin), .IO_QUERY(query),
      .IO_HIT_VALID(hit_v), .IO_FORWARD(fwd), .DOWN_BUS_NUM(down_bus),
      .HIGH_BUS_NUM(high_bus));

   // 125 MHz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // expected read value from the shadow registers
   function automatic logic [31:0] exp_rd(logic [11:0] a);
      case (a)
         `OFF_HEADER_KIND: return 32'h1;
         `OFF_UP_BUS:      return {24'h0, up_m};
         `OFF_DOWN_BUS:    return {24'h0, down_m};
         `OFF_HIGH_BUS:    return {24'h0, high_m};
         `OFF_IO_BASE:     return {24'h0, base_m, 3'h0, cap_m};
         `OFF_IO_TOP:      return {24'h0, top_m, 3'h0, cap_m};
         `OFF_CAP_LOCK:    return {30'h0, pin_m, lock_m};
         default:          return 32'h0;
      endcase
   endfunction : exp_rd

   // inclusive window, empty when base is above top
   function automatic logic exp_fwd(logic [31:0] a);
      return a[31:16] == 16'h0 && base_m <= a[15:12] && a[15:12] <= top_m;
   endfunction : exp_fwd

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one bus cycle; a write is left standing so a read may follow at once
   task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (w) begin
         case (a)
            `OFF_UP_BUS:   up_m = d[7:0];
            `OFF_DOWN_BUS: down_m = d[7:0];
            `OFF_HIGH_BUS: high_m = d[7:0];
            `OFF_IO_TOP:   top_m = d[7:4];
            `OFF_CAP_LOCK: lock_m = lock_m | d[0];
            `OFF_IO_BASE: begin
               base_m = d[7:4];
               if (!lock_m && !pin_m) cap_m = d[0];
            end
            default: ;
         endcase
      end else begin
         @(posedge clk);
         rd <= 1'b0;
         wr <= 1'b0;
         #1 chk(rdata, exp_rd(a));
         chk({24'h0, down_bus}, {24'h0, down_m});
         chk({24'h0, high_bus}, {24'h0, high_m});
      end
   endtask : acc

   // single lookup into the forwarding window
   task automatic q(logic [31:0] a);
      @(posedge clk);
      wr <= 1'b0;
      query <= '{valid: 1'b1, addr: a};
      @(posedge clk);
      query.valid <= 1'b0;
      #1 chk(32'(hit_v), 32'h1);
      chk(32'(fwd), 32'(exp_fwd(a)));
   endtask : q

   task automatic rst();
      @(posedge clk);
      rst_n <= 1'b0;
      wr <= 1'b0;
      rd <= 1'b0;
      query.valid <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      {up_m, down_m, high_m, top_m, lock_m} = '0;
      {base_m, cap_m} = 5'h1F;
   endtask : rst

   task automatic sweep();
      foreach (addrs[i]) acc(1'b0, addrs[i], 32'h0);
      $display("reset value sweep done");
   endtask : sweep

   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // cut a hang short
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      {rst_n, wr, rd, pin, pin_m, addr, wdata, query} = '0;
      void'($urandom(51));
      rst();
      sweep();
      // capability bit: free, then held by the pin, then by software lock
      acc(1'b1, `OFF_IO_BASE, 32'h30);
      acc(1'b0, `OFF_IO_TOP, 32'h0);
      pin <= 1'b1;
      pin_m = 1'b1;
      repeat (3) @(posedge clk);
      acc(1'b1, `OFF_IO_BASE, 32'h31);
      acc(1'b0, `OFF_IO_BASE, 32'h0);
      acc(1'b0, `OFF_CAP_LOCK, 32'h0);
      pin <= 1'b0;
      pin_m = 1'b0;
      repeat (3) @(posedge clk);
      acc(1'b1, `OFF_IO_BASE, 32'h31);
      acc(1'b1, `OFF_CAP_LOCK, 32'h1);
      acc(1'b1, `OFF_IO_BASE, 32'h20);
      acc(1'b0, `OFF_IO_TOP, 32'h0);
      $display("capability lock test done");
      // random traffic over every address, reads often right after writes
      repeat (200) acc(1'($urandom_range(1, 0)), addrs[$urandom_range(11, 0)],
         $urandom);
      $display("random access test done");
      // window: bounds, inside, and above the 16-bit range
      repeat (60) begin
         acc(1'b1, `OFF_IO_BASE, $urandom);
         acc(1'b1, `OFF_IO_TOP, $urandom);
         q({16'h0, base_m, 12'h000});
         q({16'h0, top_m, 12'hFFF});
         q({16'h0, top_m + 4'h1, 12'h000});
         q({16'($urandom_range(1, 0)), 16'($urandom)});
      end
      $display("io window test done");
      // reset in mid-run brings every field back
      rst();
      sweep();
      report_and_stop();
   end
endmodule : bridge_type1_header_regs_tb
